// File: src/cfmr_flag.sv
`timescale 1ns/1ps
module cfmr_flag #(
	parameter bit PERSIST = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic cond,
	input  wire logic clr,
	output      logic flag
);
	import cfmr_pkg::*;

	typedef struct packed {
		logic flag;
		logic cond_d;
	} cfmr_flag_st_t;

	cfmr_flag_st_t st_r;
	cfmr_flag_st_t st_nxt;
	logic          set;

	// ==========================================
	// Persistent flags are set by the level and held until clr, others catch a new event once
	always_comb begin
		set = PERSIST ? cond : (cond & ~st_r.cond_d);
		st_nxt.cond_d = cond;
		st_nxt.flag = set | (st_r.flag & ~clr);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign flag = st_r.flag;

endmodule

// File: src/cfmr_pkg.sv
package cfmr_pkg;

	// ==========================================
	// Register locations
	localparam logic [7:0] CFMR_OFF_FAULT = 8'h01;
	localparam logic [7:0] CFMR_OFF_TSC   = 8'h02;
	localparam logic [7:0] CFMR_OFF_FCHG  = 8'h03;
	localparam logic [7:0] CFMR_UNMAPPED  = 8'hff;

	// ==========================================
	// Fault register fields
	localparam int CFMR_B_IN_OV   = 7;
	localparam int CFMR_B_IN_UV   = 6;
	localparam int CFMR_B_BAT_LO  = 5;
	localparam int CFMR_B_BAT_OC  = 4;
	localparam int CFMR_MASK_HI   = 3;
	localparam logic [3:0] CFMR_MASK_RST = 4'h0;

	// ==========================================
	// Thermistor control fields
	localparam int CFMR_B_TH_EN   = 7;
	localparam int CFMR_B_TH_ST_H = 6;
	localparam int CFMR_B_TH_ST_L = 5;
	localparam int CFMR_B_ALT_ST  = 3;
	localparam int CFMR_B_WAKE_M  = 2;
	localparam int CFMR_B_PBRST_M = 1;
	localparam int CFMR_B_TIMER_M = 0;
	localparam logic       CFMR_TH_EN_RST  = 1'b1;
	localparam logic [3:0] CFMR_TSC_LO_RST = 4'h8;
	localparam logic [1:0] CFMR_TH_NORMAL  = 2'h0;

	// ==========================================
	// Fast charge control
	localparam logic [7:0] CFMR_FCHG_RST = 8'h18;

	// ==========================================
	// Carriers
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} cfmr_req_t;

	typedef struct packed {
		logic in_ov;
		logic in_uv;
		logic bat_lo;
		logic bat_oc;
	} cfmr_fault_t;

	typedef struct packed {
		logic wake;
		logic pb_reset;
		logic timer;
		logic chg_status;
	} cfmr_evt_t;

endpackage

// File: src/cfmr_regs.sv
`timescale 1ns/1ps
module cfmr_regs (
	input  wire logic                  CLK,
	input  wire logic                  RST,
	input  wire logic                  CE,
	input  wire cfmr_pkg::cfmr_req_t   REQ,
	input  wire cfmr_pkg::cfmr_fault_t FAULTS,
	input  wire cfmr_pkg::cfmr_evt_t   EVTS,
	input  wire logic [1:0]            TS_STATE,
	output      logic [7:0]            REG_RDATA,
	output      logic                  ALERT_N,
	output      logic                  PB_RESET_OUT,
	output      logic                  THERM_EN,
	output      logic [7:0]            FAST_CHARGE
);
	import cfmr_pkg::*;

	typedef struct packed {
		logic [3:0] mask;
		logic       therm_en;
		logic       alt_status;
		logic       wake_m;
		logic       pbrst_m;
		logic       timer_m;
		logic [7:0] fchg;
		logic [7:0] rdata;
		logic       alert_n;
		logic       pb_rst;
	} cfmr_st_t;

	cfmr_st_t   st_r;
	cfmr_st_t   st_nxt;
	logic [3:0] flags;
	logic       rd_fault;
	logic       src;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign rd_fault = REQ.rd & hit(REQ.addr, CFMR_OFF_FAULT);

	// ==========================================
	// Fault flags
	cfmr_flag #(.PERSIST(1'b1)) u_ov (
		.clk  (CLK),
		.rst  (RST),
		.ce   (CE),
		.cond (FAULTS.in_ov),
		.clr  (rd_fault),
		.flag (flags[3])
	);
	cfmr_flag #(.PERSIST(1'b0)) u_uv (
		.clk  (CLK),
		.rst  (RST),
		.ce   (CE),
		.cond (FAULTS.in_uv),
		.clr  (rd_fault),
		.flag (flags[2])
	);
	cfmr_flag #(.PERSIST(1'b1)) u_lo (
		.clk  (CLK),
		.rst  (RST),
		.ce   (CE),
		.cond (FAULTS.bat_lo),
		.clr  (rd_fault),
		.flag (flags[1])
	);
	cfmr_flag #(.PERSIST(1'b0)) u_oc (
		.clk  (CLK),
		.rst  (RST),
		.ce   (CE),
		.cond (FAULTS.bat_oc),
		.clr  (rd_fault),
		.flag (flags[0])
	);

	// ==========================================
	// Alert sources
	always_comb begin
		src = |(flags & ~st_r.mask);
		src = src | (EVTS.wake & ~st_r.wake_m);
		src = src | (EVTS.pb_reset & ~st_r.pbrst_m);
		src = src | (EVTS.timer & ~st_r.timer_m);
		src = src | (EVTS.chg_status & st_r.alt_status);
	end

	// ==========================================
	// Register access
	always_comb begin
		st_nxt = st_r;
		st_nxt.alert_n = ~src;
		st_nxt.pb_rst = EVTS.pb_reset;
		if (REQ.wr && hit(REQ.addr, CFMR_OFF_FAULT)) begin
			st_nxt.mask = REQ.wdata[CFMR_MASK_HI:0];
		end
		if (REQ.wr && hit(REQ.addr, CFMR_OFF_TSC)) begin
			st_nxt.therm_en = REQ.wdata[CFMR_B_TH_EN];
			st_nxt.alt_status = REQ.wdata[CFMR_B_ALT_ST];
			st_nxt.wake_m = REQ.wdata[CFMR_B_WAKE_M];
			st_nxt.pbrst_m = REQ.wdata[CFMR_B_PBRST_M];
			st_nxt.timer_m = REQ.wdata[CFMR_B_TIMER_M];
		end
		if (REQ.wr && hit(REQ.addr, CFMR_OFF_FCHG)) begin
			st_nxt.fchg = REQ.wdata;
		end
		if (REQ.rd) begin
			st_nxt.rdata = CFMR_UNMAPPED;
			if (hit(REQ.addr, CFMR_OFF_FAULT)) begin
				st_nxt.rdata = {flags, st_r.mask};
			end
			if (hit(REQ.addr, CFMR_OFF_TSC)) begin
				st_nxt.rdata = '0;
				st_nxt.rdata[CFMR_B_TH_EN] = st_r.therm_en;
				st_nxt.rdata[CFMR_B_TH_ST_H:CFMR_B_TH_ST_L] =
					st_r.therm_en ? TS_STATE : CFMR_TH_NORMAL;
				st_nxt.rdata[CFMR_B_ALT_ST] = st_r.alt_status;
				st_nxt.rdata[CFMR_B_WAKE_M] = st_r.wake_m;
				st_nxt.rdata[CFMR_B_PBRST_M] = st_r.pbrst_m;
				st_nxt.rdata[CFMR_B_TIMER_M] = st_r.timer_m;
			end
			if (hit(REQ.addr, CFMR_OFF_FCHG)) begin
				st_nxt.rdata = st_r.fchg;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_r <= '0;
			st_r.mask <= CFMR_MASK_RST;
			st_r.therm_en <= CFMR_TH_EN_RST;
			st_r.alt_status <= CFMR_TSC_LO_RST[CFMR_B_ALT_ST];
			st_r.wake_m <= CFMR_TSC_LO_RST[CFMR_B_WAKE_M];
			st_r.pbrst_m <= CFMR_TSC_LO_RST[CFMR_B_PBRST_M];
			st_r.timer_m <= CFMR_TSC_LO_RST[CFMR_B_TIMER_M];
			st_r.fchg <= CFMR_FCHG_RST;
			st_r.alert_n <= 1'b1;
		end else if (CE) begin
			st_r <= st_nxt;
		end
	end

	assign REG_RDATA = st_r.rdata;
	assign ALERT_N = st_r.alert_n;
	assign PB_RESET_OUT = st_r.pb_rst;
	assign THERM_EN = st_r.therm_en;
	assign FAST_CHARGE = st_r.fchg;

	// ==========================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_fault_read;
		CE && rd_fault;
	endsequence

	sequence s_fchg_write;
		CE && REQ.wr && hit(REQ.addr, CFMR_OFF_FCHG);
	endsequence

	sequence s_fchg_read;
		CE && REQ.rd && hit(REQ.addr, CFMR_OFF_FCHG);
	endsequence

	sequence s_tsc_write;
		CE && REQ.wr && hit(REQ.addr, CFMR_OFF_TSC);
	endsequence

	chk_ov_persist: assert property (CE && FAULTS.in_ov |=> flags[3])
		else $error("overvoltage flag dropped while fault present");
	chk_uv_once: assert property (s_fault_read ##0 !(FAULTS.in_uv && !u_uv.st_r.cond_d)
		|=> !flags[2])
		else $error("undervoltage flag survived read");
	chk_uv_set: assert property (CE && $rose(FAULTS.in_uv) && $past(CE)
		|=> flags[2])
		else $error("undervoltage event missed");
	chk_lo_persist: assert property (CE && FAULTS.bat_lo |=> flags[1])
		else $error("battery lockout flag dropped while fault present");
	chk_oc_clear: assert property (s_fault_read ##0 !FAULTS.bat_oc
		|=> !flags[0])
		else $error("overcurrent flag survived read");
	chk_mask_write: assert property (CE && REQ.wr && hit(REQ.addr, CFMR_OFF_FAULT)
		|=> st_r.mask == $past(REQ.wdata[3:0]))
		else $error("mask write lost");
	chk_therm_read: assert property (CE && REQ.rd && hit(REQ.addr, CFMR_OFF_TSC)
		|=> REG_RDATA[6:5] == ($past(THERM_EN) ? $past(TS_STATE) : 2'h0))
		else $error("thermistor state readback wrong");
	chk_therm_en: assert property (s_tsc_write
		|=> THERM_EN == $past(REQ.wdata[CFMR_B_TH_EN]))
		else $error("thermistor enable write lost");
	chk_fchg_write: assert property (s_fchg_write |=> FAST_CHARGE == $past(REQ.wdata))
		else $error("fast charge write lost");
	chk_fchg_read: assert property (s_fchg_read |=> REG_RDATA == $past(FAST_CHARGE))
		else $error("fast charge readback wrong");
	chk_wake_alert: assert property (CE && EVTS.wake && !st_r.wake_m
		|=> !ALERT_N)
		else $error("wake interrupt not raised");
	chk_timer_alert: assert property (CE && EVTS.timer && !st_r.timer_m
		|=> !ALERT_N)
		else $error("timer interrupt not raised");
	chk_pbrst_alert: assert property (CE && EVTS.pb_reset && !st_r.pbrst_m
		|=> !ALERT_N)
		else $error("push button reset interrupt not raised");
	chk_status_alert: assert property (CE && EVTS.chg_status && st_r.alt_status
		|=> !ALERT_N)
		else $error("charge status alert missing");
	chk_status_off: assert property (CE && EVTS.chg_status && !st_r.alt_status
		&& flags == 4'h0 && !EVTS.wake && !EVTS.pb_reset && !EVTS.timer |=> ALERT_N)
		else $error("charge status alerted while disabled");
	chk_pbrst_out: assert property (CE |=> PB_RESET_OUT == $past(EVTS.pb_reset))
		else $error("reset output not following push button");
	chk_masked_quiet: assert property (CE && !src |=> ALERT_N)
		else $error("alert raised with no unmasked source");

endmodule

// File: verification/cfmr_host.sv
`timescale 1ns/1ps
// ==========================================
// Host side of the register port
module cfmr_host (
	input  wire logic                clk,
	output      cfmr_pkg::cfmr_req_t req
);
	import cfmr_pkg::*;
	logic [7:0] exp_q[$];
	initial req = '0;
	// One strobe per byte, held for exactly one clock edge whether CE is high or low
	task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk);
		req <= '{a, w, ~w, d};
		@(posedge clk);
		req <= '{a, 1'b0, 1'b0, d};
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		acc(a, 1'b0, 8'h00);
	endtask
endmodule

// File: verification/tb_cfmr_regs.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
	$display("MISMATCH %0t got %h want %h", $time, a, e); end end
module tb_cfmr_regs;
	import cfmr_pkg::*;
	logic        CLK = 1'b0;
	logic        RST = 1'b1;
	logic        CE  = 1'b1;
	cfmr_req_t   REQ;
	cfmr_fault_t FAULTS = '0;
	cfmr_evt_t   EVTS = '0;
	logic [1:0]  TS_STATE = 2'h0;
	logic [7:0]  REG_RDATA;
	logic [7:0]  FAST_CHARGE;
	logic        ALERT_N;
	logic        PB_RESET_OUT;
	logic        THERM_EN;
	logic        rd_d = 1'b0;
	logic [7:0]  fchg_exp;
	logic [31:0] seed = 32'hd26315a2;
	logic [7:0]  v;
	logic [7:0]  m;
	int          err_total = 0;
	int          check_count = 0;

	cfmr_regs cfmr_regs_i (.CLK(CLK), .RST(RST), .CE(CE), .REQ(REQ), .FAULTS(FAULTS),
		.EVTS(EVTS), .TS_STATE(TS_STATE), .REG_RDATA(REG_RDATA), .ALERT_N(ALERT_N),
		.PB_RESET_OUT(PB_RESET_OUT), .THERM_EN(THERM_EN), .FAST_CHARGE(FAST_CHARGE));
	cfmr_host cfmr_host_i (.clk(CLK), .req(REQ));

	always #2.5 CLK = ~CLK;

	function automatic logic [7:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
	endtask

	task automatic print_verdict();
		if (err_total == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ==========================================
	// Read data watcher: answer lands one cycle after the taken read
	always @(posedge CLK) begin
		rd_d <= REQ.rd & CE;
	end
	always @(negedge CLK) begin
		if (rd_d) begin
			v = cfmr_host_i.exp_q.pop_front();
			`CHK(REG_RDATA, v)
		end
	end

	// ==========================================
	// Scenarios
	initial begin
		tick(16);
		RST <= 1'b0;
		@(negedge CLK);
		`CHK(FAST_CHARGE, CFMR_FCHG_RST)
		`CHK(THERM_EN, 1'b1)
		cfmr_host_i.rd(CFMR_OFF_FAULT, 8'h00);
		cfmr_host_i.rd(CFMR_OFF_TSC, 8'h88);
		cfmr_host_i.rd(CFMR_UNMAPPED, 8'hff);
		for (int i = 0; i < 4; i++) begin
			m = xs();
			TS_STATE <= m[1:0];
			cfmr_host_i.wr(CFMR_OFF_FCHG, m);
			fchg_exp = m;
			cfmr_host_i.rd(CFMR_OFF_TSC, {1'b1, m[1:0], 5'h08});
			cfmr_host_i.rd(CFMR_OFF_FCHG, m);
		end
		cfmr_host_i.wr(CFMR_OFF_TSC, 8'h70);
		@(negedge CLK);
		`CHK(THERM_EN, 1'b0)
		cfmr_host_i.rd(CFMR_OFF_TSC, 8'h00);
		cfmr_host_i.wr(CFMR_OFF_TSC, 8'h88);
		cfmr_host_i.wr(CFMR_OFF_FAULT, 8'hff);
		FAULTS <= 4'hf;
		tick(3);
		@(negedge CLK);
		`CHK(ALERT_N, 1'b1)
		cfmr_host_i.rd(CFMR_OFF_FAULT, 8'hff);
		cfmr_host_i.rd(CFMR_OFF_FAULT, 8'haf);
		FAULTS <= 4'h0;
		tick(2);
		cfmr_host_i.rd(CFMR_OFF_FAULT, 8'haf);
		cfmr_host_i.rd(CFMR_OFF_FAULT, 8'h0f);
		FAULTS <= 4'h4;
		tick(2);
		cfmr_host_i.rd(CFMR_OFF_FAULT, 8'h4f);
		cfmr_host_i.rd(CFMR_OFF_FAULT, 8'h0f);
		cfmr_host_i.wr(CFMR_OFF_FAULT, 8'h00);
		FAULTS <= 4'h2;
		tick(3);
		@(negedge CLK);
		`CHK(ALERT_N, 1'b0)
		tick(1);
		FAULTS <= 4'h0;
		cfmr_host_i.rd(CFMR_OFF_FAULT, 8'h20);
		tick(3);
		@(negedge CLK);
		`CHK(ALERT_N, 1'b1)
		for (int k = 0; k < 2; k++) begin
			m = k ? 8'h87 : 8'h88;
			cfmr_host_i.wr(CFMR_OFF_TSC, m);
			for (int i = 0; i < 4; i++) begin
				tick(1);
				EVTS <= 4'h1 << i;
				tick(2);
				@(negedge CLK);
				`CHK(ALERT_N, m[0])
				`CHK(PB_RESET_OUT, i == 2)
			end
			tick(1);
			EVTS <= 4'h0;
		end
		m = xs();
		tick(1);
		CE <= 1'b0;
		cfmr_host_i.wr(CFMR_OFF_FCHG, m);
		CE <= 1'b1;
		@(negedge CLK);
		`CHK(FAST_CHARGE, fchg_exp)
		tick(4);
		print_verdict();
	end

	initial begin
		#50000;
		err_total++;
		print_verdict();
	end
endmodule
